// ===== src/cfg_pkg.sv
// What this block does
// RQ1: two-bit frequency spread level, resets to zero
// RQ2: hot threshold select bits 7:6, default 10
// RQ3: cold threshold select bits 1:0, default 10
// RQ4: bit 0 enables temperature-sense pin handling
// RQ5: reverse hot threshold, 11 disables, default 01
// RQ6: reverse cold threshold bit 5, resets 0
// RQ7: read-only overload timer duration at bit 6
// RQ8: reverse undervoltage limit select, resets 1
// RQ9: passthrough forward only, cleared by watchdog
// RQ10: overcurrent in passthrough clears it, sets high-impedance
// RQ11: bit 3 selects overload re-arm by max time
// RQ12: bit 2 enables three-level overload
// RQ13: bit 1 selects overload upper limit factor
// RQ14: bit 0 enables overload mode
// RQ15: documented reset bytes, reserved bits read zero
// RQ16: register reset restores all defaults
// RQ17: writes to reserved, read-only bits ignored
// RQ18: host uses read-modify-write on whole bytes
`default_nettype none

package cfg_pkg;
    // bus address of the device; value is arbitrary
    localparam logic [6:0] DEV_ADDR    = 7'h35;
    localparam logic [3:0] BYTE_BITS   = 4'h8;

    localparam logic [7:0] SPREAD_ADDR = 8'h1a;
    localparam logic [7:0] THRESH_ADDR = 8'h1b;
    localparam logic [7:0] REGION_ADDR = 8'h1c;
    localparam logic [7:0] REV_ADDR    = 8'h1d;
    localparam logic [7:0] PASS_ADDR   = 8'h1e;

    localparam logic [7:0] SPREAD_RST  = 8'h00;
    localparam logic [7:0] THRESH_RST  = 8'h82;
    localparam logic [7:0] REGION_RST  = 8'h00;
    localparam logic [7:0] REV_RST     = 8'h40;
    localparam logic [7:0] PASS_RST    = 8'h20;

    localparam int SPREAD_LSB   = 3;
    localparam int HOT_LSB      = 6;
    localparam int COLD_LSB     = 0;
    localparam int SENSE_BIT    = 0;
    localparam int REV_HOT_LSB  = 6;
    localparam int REV_COLD_BIT = 5;
    localparam int TIMER_BIT    = 6;
    localparam int UV_BIT       = 5;
    localparam int PASS_BIT     = 4;
    localparam int OVERLOAD_MAX_TIME_BIT     = 3;
    localparam int L3_BIT       = 2;
    localparam int ILIM2_BIT    = 1;
    localparam int OVLD_BIT     = 0;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
    } i2c_state_e;
endpackage : cfg_pkg

`default_nettype wire

// ===== src/sync_2ff.sv
`default_nettype none

module sync_2ff #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // asynchronous in, synchronised out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1_q <= '1;
            sync_out <= '1;
        end else begin
            stage1_q <= async_in;
            sync_out <= stage1_q;
        end
    end
endmodule : sync_2ff

`default_nettype wire

// ===== src/converter_config_regs_1a_1e.sv
`default_nettype none

module converter_config_regs_1a_1e
    import cfg_pkg::*;
(
    // clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // i2c pins, open drain
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // events and status from the converter core
    input  wire logic       reg_reset,
    input  wire logic       watchdog_expired,
    input  wire logic       reverse_mode,
    input  wire logic       output_over_limit,
    input  wire logic       overload_timer_sel,
    // settings to the converter core
    output logic [1:0]      frequency_spreading,
    output logic [1:0]      hot_threshold_sel,
    output logic [1:0]      cold_threshold_sel,
    output logic            thermistor_sense_en,
    output logic [1:0]      rev_hot_threshold_sel,
    output logic            rev_cold_threshold_sel,
    output logic            rev_output_uv_sel,
    output logic            passthrough_en,
    output logic            high_impedance_set,
    output logic            overload_max_timer_en,
    output logic            three_level_overload_en,
    output logic            overload_upper_limit_sel,
    output logic            overload_en
);
    logic [1:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        scl_d_q;
    logic        sda_d_q;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_c;
    logic        stop_c;
    logic        byte_done;
    i2c_state_e  state_q;
    logic [3:0]  cnt_q;
    logic [7:0]  shift_q;
    logic        rw_q;
    logic        nack_q;
    logic [7:0]  ptr_q;
    logic        wr_stb_q;
    logic [7:0]  wr_addr_q;
    logic [7:0]  wr_data_q;
    logic        load_q;
    logic [7:0]  tx_q;
    logic [7:0]  rd_byte;
    logic        passthrough_q;
    logic [7:0]  img_spread;
    logic [7:0]  img_thresh;
    logic [7:0]  img_region;
    logic [7:0]  img_rev;
    logic [7:0]  img_pass;

    sync_2ff #(.W(2)) u_sync (
        .clk      (clk),
        .nrst     (nrst),
        .async_in ({scl_in, sda_in}),
        .sync_out (pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_q;
    assign scl_fall  = ~scl_s & scl_d_q;
    assign start_c   = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign stop_c    = scl_s & scl_d_q & ~sda_d_q & sda_s;
    assign byte_done = scl_fall && (cnt_q == BYTE_BITS);

    // protocol sequencer: device address, pointer byte, then data bytes
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cnt_q   <= 4'h0;
            shift_q <= 8'h00;
            rw_q    <= 1'b0;
            nack_q  <= 1'b0;
        end else if (start_c) begin
            state_q <= ST_ADDR;
            cnt_q   <= 4'h0;
        end else if (stop_c) begin
            state_q <= ST_IDLE;
        end else if (scl_rise) begin
            if (state_q == ST_RDATA_ACK) begin
                nack_q <= sda_s;
            end else begin
                shift_q <= {shift_q[6:0], sda_s};
                cnt_q   <= cnt_q + 4'h1;
            end
        end else if (scl_fall) begin
            unique case (state_q)
                ST_IDLE: begin
                end
                ST_ADDR: begin
                    if (byte_done) begin
                        rw_q    <= shift_q[0];
                        state_q <= (shift_q[7:1] == DEV_ADDR) ?
                                   ST_ADDR_ACK : ST_IDLE;
                    end
                end
                ST_ADDR_ACK: begin
                    cnt_q   <= 4'h0;
                    state_q <= rw_q ? ST_RDATA : ST_PTR;
                end
                ST_PTR: begin
                    if (byte_done) state_q <= ST_PTR_ACK;
                end
                ST_PTR_ACK: begin
                    cnt_q   <= 4'h0;
                    state_q <= ST_WDATA;
                end
                ST_WDATA: begin
                    if (byte_done) state_q <= ST_WDATA_ACK;
                end
                ST_WDATA_ACK: begin
                    cnt_q   <= 4'h0;
                    state_q <= ST_WDATA;
                end
                ST_RDATA: begin
                    if (byte_done) state_q <= ST_RDATA_ACK;
                end
                ST_RDATA_ACK: begin
                    cnt_q   <= 4'h0;
                    state_q <= nack_q ? ST_IDLE : ST_RDATA;
                end
            endcase
        end
    end

    // pointer auto-increments after every byte written or acked on read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ptr_q     <= 8'h00;
            wr_stb_q  <= 1'b0;
            wr_addr_q <= 8'h00;
            wr_data_q <= 8'h00;
            load_q    <= 1'b0;
        end else begin
            wr_stb_q <= byte_done && (state_q == ST_WDATA);
            load_q   <= scl_fall && (((state_q == ST_ADDR_ACK) && rw_q) ||
                        ((state_q == ST_RDATA_ACK) && !nack_q));
            if (byte_done && (state_q == ST_WDATA)) begin
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
            end
            if (byte_done && (state_q == ST_PTR)) begin
                ptr_q <= shift_q;
            end else if (wr_stb_q) begin
                ptr_q <= ptr_q + 8'h01;
            end else if (scl_fall && (state_q == ST_RDATA_ACK) && !nack_q) begin
                ptr_q <= ptr_q + 8'h01;
            end
        end
    end

    // read byte is fetched one cycle after the pointer settles
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_q <= 8'hff;
        end else if (load_q) begin
            tx_q <= rd_byte;
        end else if (scl_fall && (state_q == ST_RDATA)) begin
            tx_q <= {tx_q[6:0], 1'b1};
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe  = (state_q == ST_ADDR_ACK) || (state_q == ST_PTR_ACK) ||
                     (state_q == ST_WDATA_ACK) ||
                     ((state_q == ST_RDATA) && !tx_q[7]);

    // writable fields; reserved and read-only positions are never stored
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frequency_spreading      <= SPREAD_RST[SPREAD_LSB +: 2];
            hot_threshold_sel        <= THRESH_RST[HOT_LSB +: 2];
            cold_threshold_sel       <= THRESH_RST[COLD_LSB +: 2];
            thermistor_sense_en      <= REGION_RST[SENSE_BIT];
            rev_hot_threshold_sel    <= REV_RST[REV_HOT_LSB +: 2];
            rev_cold_threshold_sel   <= REV_RST[REV_COLD_BIT];
            rev_output_uv_sel        <= PASS_RST[UV_BIT];
            overload_max_timer_en    <= PASS_RST[OVERLOAD_MAX_TIME_BIT];
            three_level_overload_en  <= PASS_RST[L3_BIT];
            overload_upper_limit_sel <= PASS_RST[ILIM2_BIT];
            overload_en              <= PASS_RST[OVLD_BIT];
        end else if (reg_reset) begin                            // [RQ16]
            frequency_spreading      <= SPREAD_RST[SPREAD_LSB +: 2]; // [RQ1]
            hot_threshold_sel        <= THRESH_RST[HOT_LSB +: 2];  // [RQ2]
            cold_threshold_sel       <= THRESH_RST[COLD_LSB +: 2]; // [RQ3]
            thermistor_sense_en      <= REGION_RST[SENSE_BIT];     // [RQ4]
            rev_hot_threshold_sel    <= REV_RST[REV_HOT_LSB +: 2]; // [RQ5]
            rev_cold_threshold_sel   <= REV_RST[REV_COLD_BIT];     // [RQ6]
            rev_output_uv_sel        <= PASS_RST[UV_BIT];          // [RQ8]
            overload_max_timer_en    <= PASS_RST[OVERLOAD_MAX_TIME_BIT];        // [RQ11]
            three_level_overload_en  <= PASS_RST[L3_BIT];          // [RQ12]
            overload_upper_limit_sel <= PASS_RST[ILIM2_BIT];       // [RQ13]
            overload_en              <= PASS_RST[OVLD_BIT];        // [RQ14]
        end else if (wr_stb_q) begin                             // [RQ17]
            case (wr_addr_q)
                SPREAD_ADDR: frequency_spreading <=
                    wr_data_q[SPREAD_LSB +: 2];                    // [RQ1]
                THRESH_ADDR: begin
                    hot_threshold_sel  <= wr_data_q[HOT_LSB +: 2];  // [RQ2]
                    cold_threshold_sel <= wr_data_q[COLD_LSB +: 2]; // [RQ3]
                end
                REGION_ADDR: thermistor_sense_en <=
                    wr_data_q[SENSE_BIT];                          // [RQ4]
                REV_ADDR: begin
                    rev_hot_threshold_sel  <=
                        wr_data_q[REV_HOT_LSB +: 2];               // [RQ5]
                    rev_cold_threshold_sel <=
                        wr_data_q[REV_COLD_BIT];                   // [RQ6]
                end
                PASS_ADDR: begin
                    rev_output_uv_sel        <= wr_data_q[UV_BIT];  // [RQ8]
                    overload_max_timer_en    <= wr_data_q[OVERLOAD_MAX_TIME_BIT]; // [RQ11]
                    three_level_overload_en  <= wr_data_q[L3_BIT]; // [RQ12]
                    overload_upper_limit_sel <= wr_data_q[ILIM2_BIT]; // [RQ13]
                    overload_en              <= wr_data_q[OVLD_BIT]; // [RQ14]
                end
                default: begin
                end
            endcase
        end
    end

    // hardware clears win over a host write in the same cycle, so a trip
    // can never be masked by software re-enabling the passthrough
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            passthrough_q <= PASS_RST[PASS_BIT];
        end else if (reg_reset || watchdog_expired) begin         // [RQ9]
            passthrough_q <= PASS_RST[PASS_BIT];
        end else if (passthrough_en && output_over_limit) begin  // [RQ10]
            passthrough_q <= 1'b0;
        end else if (wr_stb_q && (wr_addr_q == PASS_ADDR)) begin
            passthrough_q <= wr_data_q[PASS_BIT];
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            passthrough_en     <= 1'b0;
            high_impedance_set <= 1'b0;
        end else begin
            passthrough_en     <= passthrough_q && !reverse_mode; // [RQ9]
            high_impedance_set <= passthrough_en && output_over_limit &&
                                  passthrough_q;                 // [RQ10]
        end
    end

    // read images with reserved bits as zero [RQ15]
    always_comb begin
        img_spread = 8'h00;
        img_thresh = 8'h00;
        img_region = 8'h00;
        img_rev    = 8'h00;
        img_pass   = 8'h00;
        img_spread[SPREAD_LSB +: 2] = frequency_spreading;
        img_thresh[HOT_LSB +: 2]    = hot_threshold_sel;
        img_thresh[COLD_LSB +: 2]   = cold_threshold_sel;
        img_region[SENSE_BIT]       = thermistor_sense_en;
        img_rev[REV_HOT_LSB +: 2]   = rev_hot_threshold_sel;
        img_rev[REV_COLD_BIT]       = rev_cold_threshold_sel;
        img_pass[TIMER_BIT]         = overload_timer_sel;        // [RQ7]
        img_pass[UV_BIT]            = rev_output_uv_sel;
        img_pass[PASS_BIT]          = passthrough_q;
        img_pass[OVERLOAD_MAX_TIME_BIT]          = overload_max_timer_en;
        img_pass[L3_BIT]            = three_level_overload_en;
        img_pass[ILIM2_BIT]         = overload_upper_limit_sel;
        img_pass[OVLD_BIT]          = overload_en;
    end

    always_comb begin
        case (ptr_q)
            SPREAD_ADDR: rd_byte = img_spread;
            THRESH_ADDR: rd_byte = img_thresh;
            REGION_ADDR: rd_byte = img_region;
            REV_ADDR:    rd_byte = img_rev;
            PASS_ADDR:   rd_byte = img_pass;
            default:     rd_byte = 8'h00;
        endcase
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    spread_write_a: assert property (                            // [RQ1]
        wr_stb_q && !reg_reset && (wr_addr_q == SPREAD_ADDR) |=>
        frequency_spreading == $past(wr_data_q[SPREAD_LSB +: 2]))
        else $error("spread field not written");
    soft_reset_image_a: assert property (         // [RQ15] [RQ2] [RQ3] [RQ16]
        reg_reset && !watchdog_expired |=>
        img_spread == SPREAD_RST && img_thresh == THRESH_RST &&
        img_region == REGION_RST && img_rev == REV_RST &&
        (img_pass & ~(8'h01 << TIMER_BIT)) == PASS_RST)
        else $error("reset image mismatch");
    sense_write_a: assert property (                             // [RQ4]
        wr_stb_q && !reg_reset && (wr_addr_q == REGION_ADDR) |=>
        thermistor_sense_en == $past(wr_data_q[SENSE_BIT]))
        else $error("sense enable not written");
    rev_hot_write_a: assert property (                      // [RQ5] [RQ6]
        wr_stb_q && !reg_reset && (wr_addr_q == REV_ADDR) |=>
        img_rev == ($past(wr_data_q) & REV_RST | $past(wr_data_q) &
        (8'h01 << REV_COLD_BIT) | $past(wr_data_q) & 8'h80))
        else $error("reverse threshold not written");
    timer_bit_a: assert property (                               // [RQ7]
        load_q && (ptr_q == PASS_ADDR) |=>
        tx_q[TIMER_BIT] == $past(overload_timer_sel))
        else $error("timer bit not tracking");
    watchdog_clear_a: assert property (                          // [RQ9]
        watchdog_expired |=> !passthrough_q ##1 !passthrough_en)
        else $error("watchdog did not clear passthrough");
    reverse_block_a: assert property (                           // [RQ9]
        reverse_mode |=> !passthrough_en)
        else $error("passthrough active in reverse");
    trip_hiz_a: assert property (                               // [RQ10]
        passthrough_en && output_over_limit |=>
        high_impedance_set && !passthrough_q)
        else $error("overcurrent trip not taken");
    reserved_zero_a: assert property (                     // [RQ15] [RQ17]
        img_spread[7:5] == 3'h0 && img_thresh[5:2] == 4'h0 &&
        img_region[7:1] == 7'h00 && img_rev[4:0] == 5'h00 && !img_pass[7])
        else $error("reserved bit reads nonzero");
    pass_write_a: assert property (               // [RQ8] [RQ11] [RQ14]
        wr_stb_q && !reg_reset && (wr_addr_q == PASS_ADDR) |=>
        overload_en == $past(wr_data_q[OVLD_BIT]) &&
        rev_output_uv_sel == $past(wr_data_q[UV_BIT]) &&
        overload_max_timer_en == $past(wr_data_q[OVERLOAD_MAX_TIME_BIT]))
        else $error("overload control not written");

    write_seen_c: cover property (wr_stb_q ##[1:400] load_q);
    trip_seen_c:  cover property (passthrough_en ##1 high_impedance_set);
    nack_seen_c:  cover property (state_q == ST_RDATA_ACK && nack_q);
endmodule : converter_config_regs_1a_1e

`default_nettype wire

// ===== verification/i2c_host_model.sv
`default_nettype none

module i2c_host_model
    import cfg_pkg::*;
(
    // clock
    input  wire logic clk,
    // bus lines, open drain with pull-up
    input  wire logic sda_line,
    output var logic  scl_out,
    output var logic  host_pull
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl_out   = 1'b1;
        host_pull = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step

    // start is (1,0), stop is (0,1); phases of 4 and 6 clocks, none below the 4-clock minimum
    task automatic frame_edge(input logic first, input logic last);
        scl_out = 1'b0;
        step(4);
        host_pull = ~first;
        step(4);
        scl_out = 1'b1;
        step(6);
        host_pull = ~last;
        step(6);
    endtask : frame_edge

    // sda moves only mid low phase, so the device's ack hold is respected
    task automatic bit_io(input logic b, output logic r);
        scl_out = 1'b0;
        step(4);
        host_pull = ~b;
        step(4);
        scl_out = 1'b1;
        step(6);
        r = sda_line;
    endtask : bit_io

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : send_byte

    task automatic write_reg(input logic [7:0] p, input logic [7:0] v,
                             output logic ack);
        logic a0, a1, a2;
        frame_edge(1'b1, 1'b0);
        send_byte({DEV_ADDR, 1'b0}, a0);
        send_byte(p, a1);
        send_byte(v, a2);
        frame_edge(1'b0, 1'b1);
        ack = a0 & a1 & a2;
    endtask : write_reg

    // master nacks the single byte, which ends the read
    task automatic read_reg(input logic [7:0] p, output logic [7:0] v,
                            output logic ack);
        logic a0, a1, a2, r;
        frame_edge(1'b1, 1'b0);
        send_byte({DEV_ADDR, 1'b0}, a0);
        send_byte(p, a1);
        frame_edge(1'b1, 1'b0);
        send_byte({DEV_ADDR, 1'b1}, a2);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, v[i]);
        end
        bit_io(1'b1, r);
        frame_edge(1'b0, 1'b1);
        ack = a0 & a1 & a2;
    endtask : read_reg
endmodule : i2c_host_model

`default_nettype wire

// ===== verification/tb_top.sv
`default_nettype none

module tb_top
    import cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic nrst, reg_reset;
    logic watchdog_expired, reverse_mode;
    logic output_over_limit, overload_timer_sel;
    wire logic scl, host_pull, sda_out, sda_oe, sda_line;
    wire logic [1:0] frequency_spreading, hot_threshold_sel;
    wire logic [1:0] cold_threshold_sel, rev_hot_threshold_sel;
    wire logic thermistor_sense_en, rev_cold_threshold_sel, passthrough_en;
    wire logic rev_output_uv_sel, high_impedance_set, overload_max_timer_en;
    wire logic three_level_overload_en, overload_upper_limit_sel, overload_en;
    logic [15:0] fvec;
    logic [7:0]  dflt [5] = '{8'h00, 8'h82, 8'h00, 8'h40, 8'h20};
    logic [7:0]  masked [5] = '{8'h18, 8'hc3, 8'h01, 8'he0, 8'h3f};
    localparam logic [15:0] RST_VEC = 16'h28a0;
    int mismatches = 0, cmp_count = 0, cycles = 0;
    logic [1:0] c;

    always #10 clk = ~clk;

    // either party pulling low wins; released line floats high
    assign sda_line = ~host_pull & ~(sda_oe & ~sda_out);
    assign fvec = {frequency_spreading, hot_threshold_sel, cold_threshold_sel,
                   thermistor_sense_en, rev_hot_threshold_sel,
                   rev_cold_threshold_sel, rev_output_uv_sel, passthrough_en,
                   overload_max_timer_en, three_level_overload_en,
                   overload_upper_limit_sel, overload_en};

    converter_config_regs_1a_1e dut (
        .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_line), .sda_out,
        .sda_oe, .reg_reset(reg_reset), .watchdog_expired(watchdog_expired),
        .reverse_mode(reverse_mode), .output_over_limit(output_over_limit),
        .overload_timer_sel(overload_timer_sel), .frequency_spreading,
        .hot_threshold_sel,
        .cold_threshold_sel, .thermistor_sense_en, .rev_hot_threshold_sel,
        .rev_cold_threshold_sel, .rev_output_uv_sel, .passthrough_en,
        .high_impedance_set, .overload_max_timer_en, .three_level_overload_en,
        .overload_upper_limit_sel, .overload_en
    );

    i2c_host_model host (
        .clk(clk), .sda_line, .scl_out(scl), .host_pull
    );

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            $display("Error at %0t: run took too long", $time);
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] p, input logic [7:0] v);
        logic a;
        host.write_reg(p, v, a);
        check(16'(a), 16'h0001, "write acknowledge");
    endtask : wr

    task automatic rd(input logic [7:0] p, input logic [7:0] e);
        logic [7:0] v;
        logic       a;
        host.read_reg(p, v, a);
        check(16'(a), 16'h0001, "read acknowledge");
        check(16'(v), 16'(e), "register read");
    endtask : rd

    // only the named bits change, the rest of the byte is carried over
    task automatic set_bits(input logic [7:0] p, input logic [7:0] m);
        logic [7:0] v;
        logic       a;
        host.read_reg(p, v, a);
        host.write_reg(p, v | m, a);
    endtask : set_bits

    initial begin
        nrst = 1'b0;
        reg_reset = 1'b0;
        watchdog_expired = 1'b0;
        reverse_mode = 1'b0;
        output_over_limit = 1'b0;
        overload_timer_sel = 1'b0;
        host.step(2);
        nrst = 1'b1;
        host.step(4);
        check(fvec, RST_VEC, "fields after reset");
        for (int i = 0; i < 5; i++) begin
            rd(SPREAD_ADDR + 8'(i), dflt[i]);
        end
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            wr(SPREAD_ADDR + 8'(i), 8'hff);
            rd(SPREAD_ADDR + 8'(i), masked[i]);
        end
        check(fvec, 16'hffff, "fields all set");
        overload_timer_sel = 1'b1;
        rd(PASS_ADDR, 8'h7f);
        wr(PASS_ADDR, 8'h00);
        rd(PASS_ADDR, 8'h40);
        overload_timer_sel = 1'b0;
        $display("test reserved and read-only bits done");
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            wr(SPREAD_ADDR, {3'h0, c, 3'h0});
            check(16'(frequency_spreading), 16'(c), "spread");
            wr(THRESH_ADDR, {c, 4'h0, ~c});
            check(16'(hot_threshold_sel), 16'(c), "hot");
            check(16'(cold_threshold_sel), {14'h0, ~c}, "cold");
            wr(REGION_ADDR, {7'h00, c[0]});
            check(16'(thermistor_sense_en), 16'(c[0]), "sense");
            wr(REV_ADDR, {c, ~c[0], 5'h00});
            check(16'(rev_hot_threshold_sel), 16'(c), "rev hot");
            check(16'(rev_cold_threshold_sel), {15'h0, ~c[0]},
                  "rev cold");
            wr(PASS_ADDR, {2'h0, c[0], 1'b0, 4'h1 << c});
            check(16'(fvec[5:0]), {10'h000, c[0], 1'b0, 4'h1 << c},
                  "overload");
            check(16'(rev_output_uv_sel), 16'(c[0]), "uv");
            check(16'(overload_en), 16'(c == 2'd0), "ovld");
            check(16'(three_level_overload_en), 16'(c == 2'd2), "3l");
            check(16'(overload_upper_limit_sel), 16'(c == 2'd1), "ilim");
        end
        $display("test field codes done");
        set_bits(PASS_ADDR, 8'h10);
        check(16'(passthrough_en), 16'h0001, "pass on");
        reverse_mode = 1'b1;
        host.step(1);
        check(16'(passthrough_en), 16'h0000, "pass in reverse");
        rd(PASS_ADDR, 8'h38);
        reverse_mode = 1'b0;
        host.step(1);
        check(16'(passthrough_en), 16'h0001, "pass back");
        output_over_limit = 1'b1;
        host.step(1);
        check(16'(high_impedance_set), 16'h0001, "trip pulse");
        output_over_limit = 1'b0;
        host.step(1);
        check(16'(high_impedance_set), 16'h0000, "pulse ends");
        check(16'(passthrough_en), 16'h0000, "pass tripped");
        rd(PASS_ADDR, 8'h28);
        output_over_limit = 1'b1;
        host.step(2);
        check(16'(high_impedance_set), 16'h0000, "no trip");
        output_over_limit = 1'b0;
        $display("test passthrough trip done");
        set_bits(PASS_ADDR, 8'h10);
        watchdog_expired = 1'b1;
        host.step(1);
        watchdog_expired = 1'b0;
        host.step(1);
        check(16'(passthrough_en), 16'h0000, "watchdog");
        rd(PASS_ADDR, 8'h28);
        $display("test watchdog done");
        reg_reset = 1'b1;
        host.step(1);
        reg_reset = 1'b0;
        check(fvec, RST_VEC, "fields after reg reset");
        for (int i = 0; i < 5; i++) begin
            rd(SPREAD_ADDR + 8'(i), dflt[i]);
        end
        $display("test register reset done");
        wr(8'h1f, 8'haa);
        rd(8'h1f, 8'h00);
        rd(8'h19, 8'h00);
        check(fvec, RST_VEC, "unmapped write");
        $display("test unmapped done");
        report_and_stop();
    end
endmodule : tb_top

`default_nettype wire
